/* File: shared/lvs_params.svh */
/*
 * Constants of the line-voltage supervisor: register addresses, reset values, timing.
 * Assumes inclusion by bare name from design files and the package.
 */
`ifndef LVS_PARAMS_SVH
`define LVS_PARAMS_SVH

// Register addresses on the internal register port
`define LVS_ADDR_STATUS_CLR   8'h0C
`define LVS_ADDR_TIMEOUT      8'h1D
`define LVS_ADDR_PERIOD       8'h27
`define LVS_ADDR_DIP_LVL      8'h1F
`define LVS_ADDR_DIP_CYC      8'h1E
`define LVS_ADDR_IRQ_EN       8'h0A
`define LVS_ADDR_STATUS       8'h0B
`define LVS_ADDR_MODE         8'h09
`define LVS_ADDR_OFFSET1      8'h0D

// Reset values
`define LVS_TIMEOUT_RST       12'hFFF
`define LVS_DIP_LVL_RST       8'hFF
`define LVS_DIP_CYC_RST       8'hFF
`define LVS_IRQ_EN_RST        3'h0
`define LVS_MODE_RST          1'h0
`define LVS_OFFSET1_RST       6'h00

// Status and enable bit positions
`define LVS_BIT_DIP           0
`define LVS_BIT_TIMEOUT       1
`define LVS_BIT_CROSS         2
// Mode register bit that masks dip and timeout on the dip alert pin; supply low still drives it
`define LVS_BIT_DIP_DIS       0
// Integrator enable is the top bit of the channel-one offset word
`define LVS_BIT_INTEG         5

// Timing: timeout tick every 128 master clocks
`define LVS_TICK_DIV          128
// Period counter tick: nominal master clock 3579545 Hz, 60 Hz -> 7576 counts
`define LVS_MCLK_HZ           3579545
`define LVS_PERIOD_HZ_X60     (7576 * 60)
// Ref clock of this design
`define LVS_REF_HZ            100000000

`endif

/* File: shared/lvs_pkg.sv */
/*
 * Types of the line-voltage supervisor.
 * Assumes the params header is on the include path.
 */
`include "lvs_params.svh"
package lvs_pkg;
  // Dip detector states
  typedef enum logic [1:0] {
    LVS_DIP_IDLE,
    LVS_DIP_COUNT,
    LVS_DIP_ALERT
  } lvs_dip_state_t;

  // Magnitude byte compared against the dip level: bits 14..7 are the top byte
  // of the magnitude after its one-bit left shift
  function automatic logic [7:0] lvs_mag_byte(input logic signed [15:0] s);
    logic [15:0] a;
    a = s[15] ? 16'(-s) : s;
    return a[14:7];
  endfunction : lvs_mag_byte
endpackage : lvs_pkg

/* File: design/lvs_tick_div.sv */
/*
 * Fractional tick generator: emits a one-cycle enable at an average rate.
 * Assumes one clock; INC/MOD ratio gives the tick rate relative to the clock.
 */
`timescale 1ns/1ns
module lvs_tick_div #(
  parameter int unsigned INC = 1,
  parameter int unsigned MOD = 128
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  import lvs_pkg::*;

  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic        tick_reg;
  logic        tick_next;

  // Phase accumulator; wraps add a tick, keeps long-run rate exact
  always_comb begin
    if (acc_reg + 32'(INC) >= 32'(MOD)) begin
      acc_next  = acc_reg + 32'(INC) - 32'(MOD);
      tick_next = 1'b1;
    end else begin
      acc_next  = acc_reg + 32'(INC);
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule : lvs_tick_div

/* File: design/lvs_lowpass.sv */
/*
 * Single-pole low-pass on the voltage-channel samples (voltage_lowpass_stage).
 * Assumes sample_valid_i pulses once per new sample.
 */
`timescale 1ns/1ns
module lvs_lowpass #(
  parameter int unsigned SHIFT = 4
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               sample_valid_i,
  input  wire logic signed [15:0] sample_i,
  output logic                    out_valid_o,
  output logic signed [15:0]      out_o
);
  import lvs_pkg::*;

  logic signed [23:0] acc_reg;
  logic signed [23:0] acc_next;
  logic signed [24:0] diff;
  logic               vld_reg;

  // y += (x - y) >> SHIFT, extra fraction bits keep the pole accurate
  // Difference kept signed with a guard bit so negative steps shift arithmetically
  always_comb begin
    diff     = $signed({sample_i[15], sample_i, 8'h00}) - $signed({acc_reg[23], acc_reg});
    acc_next = acc_reg;
    if (sample_valid_i)
      acc_next = acc_reg + 24'(diff >>> SHIFT);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg <= 24'sh0;
      vld_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      vld_reg <= sample_valid_i;
    end
  end

  assign out_o       = acc_reg[23:8];
  assign out_valid_o = vld_reg;
endmodule : lvs_lowpass

/* File: design/lvs_supervisor.sv */
/*
 * Line-voltage supervisor: crossing output, crossing timeout, line period,
 * dip detection, supply-monitor inactive state and integrator enable.
 * Assumes a simple synchronous register port and raw voltage samples, low-pass filtered inside.
 */
//
// Contract
// - Integrator off after reset; on only while offset word top bit set.
// - Crossing output rises on positive crossing, falls on negative crossing.
// - Crossings detected on low-pass output, not on raw samples.
// - Crossing sets its status flag; interrupt low when enabled.
// - Status-with-clear read returns flags and interrupt to inactive.
// - Timeout is unsigned 12 bits, decrements once per 128 master clocks.
// - Every crossing reloads timeout with the programmed value.
// - Programmed reload value is all ones after reset.
// - Timeout reaching zero drives dip alert low unless disabled.
// - Timeout zero always sets its flag; interrupt only when enabled.
// - Timeout reload readable and writable at its register address.
// - Unsigned 15-bit period register refreshed every line period.
// - Period count rate gives about 7576 at 60 Hz nominal clock.
// - Supply-low state keeps block inactive, no energy accumulation.
// - Dip alert held low while supply-low state lasts.
// - Dip for programmed cycles (count plus two) asserts alert unless disabled.
// - Dip sets its flag; interrupt low when dip enabled.
// - Dip alert returns high when magnitude exceeds dip level.
// - Level compared with shifted magnitude of low-pass top byte.
// - Below-threshold when level register greater than shifted byte.
`timescale 1ns/1ns
`include "lvs_params.svh"
module lvs_supervisor (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               sample_valid_i,
  input  wire logic signed [15:0] sample_i,
  input  wire logic               supply_low_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [15:0]        reg_wdata_i,
  output logic [15:0]             reg_rdata_o,
  output logic                    line_crossing_output_o,
  output logic                    irq_n_o,
  output logic                    dip_alert_n_o,
  output logic                    integrator_en_o,
  output logic                    active_o
);
  import lvs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Tick generators and filter
  logic               tick_to;
  logic               tick_per;
  logic               lp_valid;
  logic signed [15:0] lp_out;

  // Timeout tick: 128 master clocks; master clock is the nominal rate
  lvs_tick_div #(.INC(`LVS_MCLK_HZ / 1000), .MOD(`LVS_TICK_DIV * (`LVS_REF_HZ / 1000))) u_tick_to (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (tick_to)
  );

  // Period tick: rate chosen so a 60 Hz line counts 7576
  lvs_tick_div #(.INC(`LVS_PERIOD_HZ_X60), .MOD(`LVS_REF_HZ)) u_tick_per (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (tick_per)
  );

  // Crossings only ever see filtered data, so edges lag the input
  lvs_lowpass u_lp (
    .ref_clk_i      (ref_clk_i),
    .rst_n_i        (rst_n_i),
    .sample_valid_i (sample_valid_i),
    .sample_i       (sample_i),
    .out_valid_o    (lp_valid),
    .out_o          (lp_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [11:0]    reload_reg, reload_next;
  logic [11:0]    tout_reg, tout_next;
  logic [14:0]    pcnt_reg, pcnt_next;
  logic [14:0]    period_reg, period_next;
  logic [7:0]     lvl_reg, lvl_next;
  logic [7:0]     cyc_reg, cyc_next;
  logic [7:0]     dcnt_reg, dcnt_next;
  logic [2:0]     en_reg, en_next;
  logic [2:0]     stat_reg, stat_next;
  logic           dis_reg, dis_next;
  logic [5:0]     ofs_reg, ofs_next;
  logic           sign_reg, sign_next;
  logic           zx_reg, zx_next;
  logic           below_reg, below_next;
  logic           alert_reg, alert_next;
  logic           irq_n_reg, irq_n_next;
  logic           act_reg, act_next;
  logic [15:0]    rdata_reg, rdata_next;
  lvs_dip_state_t dst_reg, dst_next;

  logic cross_pos;
  logic cross_neg;
  logic cross_any;
  logic tout_hit;
  logic below;
  logic clr_rd;

  // Sign change of filtered samples marks a crossing
  always_comb begin
    cross_pos = lp_valid && !lp_out[15] && sign_reg;
    cross_neg = lp_valid && lp_out[15] && !sign_reg;
    cross_any = cross_pos || cross_neg;
    tout_hit  = tick_to && (tout_reg == 12'h001) && !cross_any;
    below     = lvl_reg > lvs_mag_byte(lp_out);
    clr_rd    = reg_rd_i && (reg_addr_i == `LVS_ADDR_STATUS_CLR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    reload_next = reload_reg;
    tout_next   = tout_reg;
    pcnt_next   = pcnt_reg;
    period_next = period_reg;
    lvl_next    = lvl_reg;
    cyc_next    = cyc_reg;
    dcnt_next   = dcnt_reg;
    en_next     = en_reg;
    stat_next   = stat_reg;
    dis_next    = dis_reg;
    ofs_next    = ofs_reg;
    sign_next   = lp_valid ? lp_out[15] : sign_reg;
    zx_next     = zx_reg;
    below_next  = lp_valid ? below : below_reg;
    dst_next    = dst_reg;
    act_next    = !supply_low_i;
    rdata_next  = rdata_reg;

    // Host writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `LVS_ADDR_TIMEOUT:  reload_next = reg_wdata_i[11:0];
        `LVS_ADDR_DIP_LVL:  lvl_next    = reg_wdata_i[7:0];
        `LVS_ADDR_DIP_CYC:  cyc_next    = reg_wdata_i[7:0];
        `LVS_ADDR_IRQ_EN:   en_next     = reg_wdata_i[2:0];
        `LVS_ADDR_MODE:     dis_next    = reg_wdata_i[`LVS_BIT_DIP_DIS];
        `LVS_ADDR_OFFSET1:  ofs_next    = reg_wdata_i[5:0];
        default: ;
      endcase
    end

    // Host reads; clearing read drops flags, new events below win
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LVS_ADDR_TIMEOUT:     rdata_next = {4'h0, reload_reg};
        `LVS_ADDR_PERIOD:      rdata_next = {1'b0, period_reg};
        `LVS_ADDR_DIP_LVL:     rdata_next = {8'h00, lvl_reg};
        `LVS_ADDR_DIP_CYC:     rdata_next = {8'h00, cyc_reg};
        `LVS_ADDR_IRQ_EN:      rdata_next = {13'h0, en_reg};
        `LVS_ADDR_MODE:        rdata_next = {15'h0, dis_reg};
        `LVS_ADDR_OFFSET1:     rdata_next = {10'h0, ofs_reg};
        `LVS_ADDR_STATUS,
        `LVS_ADDR_STATUS_CLR:  rdata_next = {13'h0, stat_reg};
        default:               rdata_next = 16'h0000;
      endcase
    end
    if (clr_rd)
      stat_next = 3'h0;

    // Crossing output and flag
    if (cross_pos)
      zx_next = 1'b1;
    if (cross_neg)
      zx_next = 1'b0;
    if (cross_any)
      stat_next[`LVS_BIT_CROSS] = 1'b1;

    // Timeout counter: reload on crossing, else count down
    if (cross_any)
      tout_next = reload_reg;
    else if (tick_to && tout_reg != 12'h000)
      tout_next = tout_reg - 12'h001;
    if (tout_hit)
      stat_next[`LVS_BIT_TIMEOUT] = 1'b1;

    // Period: counts between positive crossings, saturates at 15 bits
    if (cross_pos) begin
      period_next = pcnt_reg;
      pcnt_next   = 15'h0000;
    end else if (tick_per && pcnt_reg != 15'h7FFF) begin
      pcnt_next = pcnt_reg + 15'h0001;
    end

    // Dip detector counts line cycles at positive crossings
    case (dst_reg)
      LVS_DIP_IDLE: begin
        if (cross_pos && below_reg) begin
          dst_next  = LVS_DIP_COUNT;
          dcnt_next = 8'h00;
        end
      end
      LVS_DIP_COUNT: begin
        if (lp_valid && !below)
          dst_next = LVS_DIP_IDLE;
        else if (cross_pos) begin
          // Count plus two cycles gives the alert at end of cycle five for 3
          if (dcnt_reg == cyc_reg + 8'h01) begin
            dst_next = LVS_DIP_ALERT;
            stat_next[`LVS_BIT_DIP] = 1'b1;
          end else
            dcnt_next = dcnt_reg + 8'h01;
        end
      end
      LVS_DIP_ALERT: begin
        if (lp_valid && !below)
          dst_next = LVS_DIP_IDLE;
      end
      default: dst_next = LVS_DIP_IDLE;
    endcase

    // Outputs; alert low on dip, timeout at zero, or supply low
    alert_next = !(((dst_reg == LVS_DIP_ALERT || tout_reg == 12'h000) && !dis_reg)
                   || supply_low_i);
    irq_n_next = !(|(stat_next & en_reg));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_reg <= `LVS_TIMEOUT_RST;
      tout_reg   <= `LVS_TIMEOUT_RST;
      pcnt_reg   <= 15'h0000;
      period_reg <= 15'h0000;
      lvl_reg    <= `LVS_DIP_LVL_RST;
      cyc_reg    <= `LVS_DIP_CYC_RST;
      dcnt_reg   <= 8'h00;
      en_reg     <= `LVS_IRQ_EN_RST;
      stat_reg   <= 3'h0;
      dis_reg    <= `LVS_MODE_RST;
      ofs_reg    <= `LVS_OFFSET1_RST;
      sign_reg   <= 1'b0;
      zx_reg     <= 1'b0;
      below_reg  <= 1'b0;
      alert_reg  <= 1'b1;
      irq_n_reg  <= 1'b1;
      act_reg    <= 1'b0;
      rdata_reg  <= 16'h0000;
      dst_reg    <= LVS_DIP_IDLE;
    end else begin
      reload_reg <= reload_next;
      tout_reg   <= tout_next;
      pcnt_reg   <= pcnt_next;
      period_reg <= period_next;
      lvl_reg    <= lvl_next;
      cyc_reg    <= cyc_next;
      dcnt_reg   <= dcnt_next;
      en_reg     <= en_next;
      stat_reg   <= stat_next;
      dis_reg    <= dis_next;
      ofs_reg    <= ofs_next;
      sign_reg   <= sign_next;
      zx_reg     <= zx_next;
      below_reg  <= below_next;
      alert_reg  <= alert_next;
      irq_n_reg  <= irq_n_next;
      act_reg    <= act_next;
      rdata_reg  <= rdata_next;
      dst_reg    <= dst_next;
    end
  end

  // Integrator enable is its own register, loaded with the next offset top bit
  logic integ_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      integ_reg <= 1'b0;
    else
      integ_reg <= ofs_next[`LVS_BIT_INTEG];
  end

  assign reg_rdata_o            = rdata_reg;
  assign line_crossing_output_o = zx_reg;
  assign irq_n_o                = irq_n_reg;
  assign dip_alert_n_o          = alert_reg;
  assign integrator_en_o        = integ_reg;
  assign active_o               = act_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Enable and stored bit are registered on the same edge, so they must always agree
  a_integ_off_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    integrator_en_o == ofs_reg[`LVS_BIT_INTEG]) else $error("integrator enable differs from its bit");
  a_zx_rises: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cross_pos |=> line_crossing_output_o) else $error("crossing output did not rise");
  a_zx_falls: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cross_neg |=> !line_crossing_output_o) else $error("crossing output did not fall");
  a_cross_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cross_any |=> stat_reg[`LVS_BIT_CROSS]) else $error("crossing flag not set");
  a_clear_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clr_rd && !cross_any && !tout_hit && !(dst_reg == LVS_DIP_COUNT)
      |=> stat_reg == 3'h0 && irq_n_o) else $error("status read did not clear");
  a_tout_reload: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cross_any |=> tout_reg == $past(reload_reg)) else $error("timeout not reloaded");
  a_tout_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tout_hit |=> stat_reg[`LVS_BIT_TIMEOUT] && tout_reg == 12'h000) else $error("timeout flag missing");
  a_tout_alert: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tout_hit && !dis_reg |=> ##1 !dip_alert_n_o) else $error("timeout did not pull alert low");
  a_supply_alert: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    supply_low_i |=> !dip_alert_n_o && !active_o) else $error("alert high in supply-low state");
  a_period_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cross_pos |=> period_reg == $past(pcnt_reg) && pcnt_reg == 15'h0000) else $error("period not latched");
endmodule : lvs_supervisor

/* File: testbench/lvs_line_src.sv */
/*
 * Voltage-channel source model: square-wave samples, one every 4 clocks.
 * Assumes the bench sets amp_i and hold_i between samples.
 */
`timescale 1ns/1ns
module lvs_line_src (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] amp_i,
  input  wire logic        hold_i,
  output logic             sample_valid_o,
  output logic [15:0]      sample_o
);
  int   div;
  int   cnt;
  logic neg;
  // Flip polarity every 275 samples; hold freezes it to fake a lost line
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 0;
      cnt <= 0;
      neg <= 1'b0;
      sample_valid_o <= 1'b0;
      sample_o <= 16'h0000;
    end else begin
      div <= (div == 3) ? 0 : div + 1;
      sample_valid_o <= (div == 3);
      if (div == 3) begin
        sample_o <= neg ? 16'(-amp_i) : amp_i;
        cnt <= (cnt == 274 || hold_i) ? 0 : cnt + 1;
        if (cnt == 274 && !hold_i) begin
          neg <= !neg;
        end
      end
    end
  end
endmodule : lvs_line_src

/* File: testbench/lvs_supervisor_bench.sv */
/*
 * Bench of the line-voltage supervisor: register rows, then supply,
 * crossing, interrupt, period, dip and timeout cases.
 * Assumes lvs_line_src as the voltage-channel source.
 */
`timescale 1ns/1ns
module lvs_supervisor_bench;
  typedef struct {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } lvs_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sv;
  logic [15:0] smp;
  logic        sup = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        zx;
  logic        irq_n;
  logic        alert_n;
  logic        integ;
  logic        act;
  logic [15:0] amp = 16'h2000;
  logic        hold = 1'b0;
  logic [15:0] v;
  int          fails = 0;
  int          n_checks = 0;
  int          n;
  lvs_row_t    rows [9] = '{
    '{1'b0, 8'h1D, 16'h0000, 16'h0FFF}, '{1'b0, 8'h1E, 16'h0000, 16'h00FF},
    '{1'b0, 8'h1F, 16'h0000, 16'h00FF}, '{1'b0, 8'h0A, 16'h0000, 16'h0000},
    '{1'b1, 8'h1D, 16'h0ABC, 16'h0ABC}, '{1'b1, 8'h1F, 16'h0000, 16'h0000},
    '{1'b1, 8'h1E, 16'h0001, 16'h0001}, '{1'b1, 8'h55, 16'h1234, 16'h0000},
    '{1'b1, 8'h0D, 16'h003F, 16'h003F}};

  // 100 MHz clock
  always #5 clk = !clk;

  lvs_line_src src (.ref_clk_i(clk), .rst_n_i(rst_n), .amp_i(amp), .hold_i(hold),
                    .sample_valid_o(sv), .sample_o(smp));
  lvs_supervisor dut (.ref_clk_i(clk), .rst_n_i(rst_n), .sample_valid_i(sv), .sample_i(smp),
                      .supply_low_i(sup), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
                      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .line_crossing_output_o(zx),
                      .irq_n_o(irq_n), .dip_alert_n_o(alert_n), .integrator_en_o(integ),
                      .active_o(act));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16

  task automatic check_bit(input logic got, input logic exp);
    check16({15'h0000, got}, {15'h0000, exp});
  endtask : check_bit

  // Request held for exactly one sampling edge
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_read

  // Bounded wait for a fall then a rise of the crossing output
  task automatic wait_rise();
    int k;
    k = 0;
    while (zx !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    while (zx !== 1'b1 && k < 6000) begin
      @(posedge clk);
      k++;
    end
    check_bit(k < 6000, 1'b1);
  endtask : wait_rise

  ////////////////////////////////////////////////////////////////////////////
  // Whole run is near 27k cycles; the limit leaves a wide margin
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge clk);
    check_bit(integ, 1'b0);
    check_bit(irq_n & alert_n, 1'b1);
    rst_n <= 1'b1;
    // Register rows: reset values, write and read back, unmapped address
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        reg_write(rows[i].addr, rows[i].wdata);
      end
      reg_read(rows[i].addr);
      check16(v, rows[i].exp);
    end
    check_bit(integ, 1'b1);
    reg_write(8'h0D, 16'h001F);
    @(posedge clk);
    check_bit(integ, 1'b0);
    // Supply below trip: inactive, alert held low
    sup <= 1'b1;
    repeat (3) @(posedge clk);
    check_bit(act, 1'b0);
    check_bit(alert_n, 1'b0);
    sup <= 1'b0;
    repeat (3) @(posedge clk);
    check_bit(act & alert_n, 1'b1);
    // Crossing flag with and without its enable
    reg_write(8'h0A, 16'h0004);
    reg_read(8'h0C);
    wait_rise();
    repeat (3) @(posedge clk);
    check_bit(irq_n, 1'b0);
    reg_read(8'h0C);
    check_bit(v[2], 1'b1);
    repeat (2) @(posedge clk);
    check_bit(irq_n, 1'b1);
    reg_write(8'h0A, 16'h0000);
    wait_rise();
    repeat (3) @(posedge clk);
    check_bit(irq_n, 1'b1);
    reg_read(8'h0B);
    check_bit(v[2], 1'b1);
    // Period of 2200 clocks at 454560 Hz counts is about 10
    wait_rise();
    reg_read(8'h27);
    check_bit(v >= 9 && v <= 11, 1'b1);
    // Dip: magnitude byte 10h under level 20h for count plus two cycles
    reg_write(8'h1F, 16'h0020);
    reg_write(8'h1E, 16'h0001);
    reg_write(8'h0A, 16'h0001);
    amp <= 16'h0800;
    reg_read(8'h0C);
    n = 0;
    while (alert_n !== 1'b0 && n < 6) begin
      wait_rise();
      repeat (3) @(posedge clk);
      n++;
    end
    check_bit(n >= 2 && n <= 5, 1'b1);
    check_bit(irq_n, 1'b0);
    reg_read(8'h0C);
    check_bit(v[0], 1'b1);
    amp <= 16'h2000;
    n = 0;
    while (alert_n !== 1'b1 && n < 2200) begin
      @(posedge clk);
      n++;
    end
    check_bit(alert_n, 1'b1);
    // Timeout: reload 3, line lost right after a crossing
    reg_write(8'h1F, 16'h0000);
    reg_write(8'h0A, 16'h0002);
    reg_write(8'h1D, 16'h0003);
    reg_read(8'h0C);
    wait_rise();
    hold <= 1'b1;
    n = 0;
    while (alert_n !== 1'b0 && n < 13000) begin
      @(posedge clk);
      n++;
    end
    check_bit(n > 7000 && n < 12000, 1'b1);
    repeat (2) @(posedge clk);
    check_bit(irq_n, 1'b0);
    reg_read(8'h0C);
    check_bit(v[1], 1'b1);
    reg_read(8'h1D);
    check16(v, 16'h0003);
    hold <= 1'b0;
    wait_rise();
    repeat (3) @(posedge clk);
    check_bit(alert_n, 1'b1);
    wrap_up();
  end
endmodule : lvs_supervisor_bench
